// ===== dv/epr_sys_model.sv
// Behavioural system logic that drives the interrupt and debug pins
`timescale 1ns/10ps
`default_nettype none
module epr_sys_model (
    input wire logic [7:0] req,
    output logic [7:0] pin
);
    // Pins 0..4 are active low and rest high, pins 5..7 are active high
    assign pin = req ^ 8'h1F;
endmodule
`default_nettype wire

// ===== dv/tb_exception_priority_resolver.sv
// Self-checking bench for the exception priority resolver
`timescale 1ns/10ps
`default_nettype none
module tb_exception_priority_resolver;
    import epr_pkg::*;
    // ************************************************************
    // Stimulus, expectations and checks
    // ************************************************************
    localparam logic [41:0] BASE = 42'h1000041000;
    localparam logic [41:0] LVL = 42'h201F;
    localparam logic [11:0] C = 12'h19F;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_v = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, exc_valid, imp;
    logic [4:0] exc_priority;
    logic [5:0] vix;
    logic [41:0] ev = BASE;
    logic [7:0] req = 8'h00, pin;
    logic [10:0] q [$];
    int fails = 0, samples_checked = 0, seed = 59790;
    always #5 pclk = ~pclk;
    epr_sys_model partner (.req(req), .pin(pin));
    epr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_reset_pin_n(pin[0]),
    .nmi_pin_n(pin[1]), .mcheck_pin_n(pin[2]), .critical_pin_n(pin[3]), .ext_irq_pin_n(pin[4]),
    .uncond_debug_pin(pin[5]), .ext_debug_event_pin_a(pin[6]), .ext_debug_event_pin_b(pin[7]),
    .wdog_reset_ctl(ev[0]), .dbg_reset_ctl(ev[1]), .cache_parity_err(ev[2]), .handler_fetch_fault(ev[3]),
    .ext_bus_err(ev[4]), .debug_counter_a_event(ev[5]), .debug_counter_b_event(ev[6]),
    .imprecise_debug_event(ev[7]), .wdog_timeout(ev[8]), .fixed_interval_timer(ev[9]), .decrementer_evt(ev[10]),
    .perf_mon_evt(ev[11]), .recoverable(ev[12]), .user_mode(ev[13]), .fetch_exc_valid(ev[14]),
    .fetch_iac(ev[15]), .fetch_itlb_miss(ev[16]), .fetch_isi(ev[17]), .fetch_next_exec(ev[18]),
    .redirect(ev[19]), .exec_valid(ev[20]), .exec_illegal(ev[21]), .exec_priv(ev[22]), .exec_unavail(ev[23]),
    .exec_brt(ev[24]), .exec_trap(ev[25]), .exec_ret(ev[26]), .exec_cret(ev[27]), .exec_sc(ev[28]),
    .exec_fp_data(ev[29]), .exec_fp_round(ev[30]), .exec_align(ev[31]), .exec_dac(ev[32]),
    .data_translation_miss(ev[33]), .exec_dsi(ev[34]), .exec_cache_lock(ev[35]), .older_done(ev[36]),
    .older_exc(ev[37]), .instr_complete(ev[38]), .post_dac(ev[39]), .post_icmp(ev[40]), .take_ack(ev[41]),
    .exc_valid(exc_valid), .exc_priority(exc_priority), .vector_offset_index(vix), .imprecise_debug_flag(imp));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tmo;
        fails++;
        give_verdict();
    endtask
    // Bounded wait for a winner flag level
    task automatic wait_v(input logic v);
        int i;
        for (i = 0; i < 30 && exc_valid !== v; i++) @(posedge pclk);
        if (exc_valid !== v) tmo();
    endtask
    // One APB transfer, held until pready; on a read, data and slverr checked against e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) tmo();
        if (!w) chk("rdata", prdata, e[31:0]);
        if (!w) chk("slverr", {31'h0, pslverr}, {31'h0, e[32]});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Raise sources m = {events, pins}, expect a winner, take it
    task automatic run(input logic [11:0] c, input logic [49:0] m, input logic [4:0] pr, input logic [5:0] ix);
        apb(1'b1, EPR_PEND_OFF, 32'h1F, 33'h0);
        apb(1'b1, EPR_CTRL_OFF, {20'h0, c}, 33'h0);
        @(posedge pclk);
        ev <= BASE | m[49:8];
        req <= m[7:0];
        q.push_back({pr, ix});
        @(posedge pclk);
        ev <= BASE | (m[49:8] & LVL);
        wait_v(1'b1);
        ev <= BASE;
        req <= 8'h00;
        repeat (4) @(posedge pclk);
        if (exc_valid === 1'b1) ev <= BASE | 42'h20000000000;
        @(posedge pclk);
        ev <= BASE;
        wait_v(1'b0);
    endtask
    // A new winner is checked against the oldest note
    always @(posedge pclk) begin
        if (exc_valid === 1'b1 && last_v !== 1'b1) begin
            if (q.size() == 0) chk("spurious", 32'h1, 32'h0);
            else chk("winner", {21'h0, exc_priority, vix}, {21'h0, q.pop_front()});
        end
        last_v <= exc_valid;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, EPR_CTRL_OFF, 32'h0, 33'h0);
        r = $random(seed);
        apb(1'b1, EPR_CTRL_OFF, r, 33'h0);
        apb(1'b0, EPR_CTRL_OFF, 32'h0, {21'h0, r[11:0]});
        apb(1'b0, 12'h010, 32'h0, 33'h100000000);
        apb(1'b1, EPR_CTRL_OFF, 32'h01E, 33'h0);
        @(posedge pclk) ev <= BASE | 42'h200;
        @(posedge pclk) ev <= 42'h315000;
        @(posedge pclk) ev <= 42'h2000081000;
        @(posedge pclk) ev <= BASE;
        repeat (8) @(posedge pclk);
        apb(1'b0, EPR_PEND_OFF, 32'h0, 33'h4);
        run(C, 50'h20000, 5'h07, 6'h0B);
        run(C, 50'hE0000, 5'h07, 6'h0B);
        run(C, 50'h40000, 5'h08, 6'h0A);
        run(C, 50'h80000, 5'h09, 6'h23);
        run(C, 50'h10000, 5'h05, 6'h0C);
        for (int k = 13; k < 16; k++) run(C, 50'h1 << k, 5'h03, 6'h0F);
        for (int k = 10; k < 13; k++) run(C, 50'h1 << k, 5'h01, 6'h01);
        for (int k = 8; k < 10; k++) run(C, 50'h1 << k, 5'h00, 6'h00);
        run(C, 50'h18, 5'h04, 6'h00);
        run(C, 50'h10, 5'h06, 6'h04);
        run(C, 50'hF0, 5'h03, 6'h0F);
        run(C, 50'h0B, 5'h00, 6'h00);
        run(C, 50'h0A, 5'h01, 6'h01);
        run(C, 50'h04, 5'h01, 6'h01);
        run(C, 50'hC00000, 5'h0A, 6'h0F);
        run(C, 50'h1400000, 5'h0B, 6'h0E);
        run(C, 50'h2400000, 5'h0C, 6'h00);
        run(C, 50'h8030000000, 5'h0D, 6'h06);
        run(C, 50'h50200000, 5'h0E, 6'h06);
        run(C, 50'h90000000, 5'h0F, 6'h20);
        run(12'h39F, 50'h110000000, 5'h11, 6'h0F);
        run(C, 50'h210000000, 5'h12, 6'h06);
        run(C, 50'h1010000000, 5'h12, 6'h08);
        run(C, 50'h8010000000, 5'h13, 6'h05);
        run(C, 50'h20010000000, 5'h15, 6'h0D);
        run(C, 50'h40010000000, 5'h16, 6'h02);
        run(C, 50'h30010000000, 5'h14, 6'h0F);
        run(C, 50'h1400000000000, 5'h1A, 6'h0F);
        run(12'h1BF, 50'h20000, 5'h07, 6'h0B);
        q.push_back({5'h18, 6'h0F});
        repeat (2) @(posedge pclk);
        chk("flag", {31'h0, imp}, 32'h1);
        chk("left", q.size(), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== hw/epr_pick.sv
// Fixed priority picker: level 0 is the most urgent
`timescale 1ns/10ps
`default_nettype none
module epr_pick
    import epr_pkg::*;
(
    epr_sel_if.pick sel
);
    logic [EPR_NPRI-1:0] above;
    logic [EPR_NPRI-1:0] grant;
    // ************************************************************
    // Grant chain
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < EPR_NPRI; i++) begin : g_chain
            if (i == 0) begin : g_first
                assign above[i] = 1'b0;
            end else begin : g_rest
                assign above[i] = above[i-1] | sel.req[i-1];
            end
            // RULE24: one winner only
            assign grant[i] = sel.req[i] & ~above[i];
        end
    endgenerate
    assign sel.hit = |sel.req;
    // Encode the single granted level
    always_comb begin
        sel.prio = 5'h00;
        sel.vec = 6'h00;
        for (int k = 0; k < EPR_NPRI; k++) begin
            if (grant[k]) begin
                sel.prio = 5'(k);
                sel.vec = sel.idx[k];
            end
        end
    end
    // Grant stays one-hot and covers any request
    a_grant_single: assert property (@(posedge sel.clk) sel.hit |-> (sel.req[sel.prio] &&  // RULE24
        (sel.req & ((27'h1 << sel.prio) - 27'h1)) == '0 && sel.vec == sel.idx[sel.prio]))
        else $error("picker winner is not the most urgent");
    a_grant_onehot: assert property (@(posedge sel.clk) sel.hit |-> $onehot(grant))  // RULE24
        else $error("picker granted zero or several levels");
endmodule
`default_nettype wire

// ===== hw/epr_pkg.sv
// Constants shared by the exception priority resolver files
package epr_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int EPR_NPRI = 27;
    localparam int EPR_CW = 12;
    localparam int EPR_PW = 5;
    localparam int EPR_XW = 12;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [11:0] EPR_CTRL_OFF = 12'h000;
    localparam logic [11:0] EPR_STAT_OFF = 12'h004;
    localparam logic [11:0] EPR_PEND_OFF = 12'h008;
    localparam logic [11:0] EPR_DBG_OFF = 12'h00C;
    // ************************************************************
    // Control fields and reset values
    // ************************************************************
    localparam int EPR_C_EE = 0;
    localparam int EPR_C_CE = 1;
    localparam int EPR_C_DE = 2;
    localparam int EPR_C_IDM = 3;
    localparam int EPR_C_MCPE = 4;
    localparam int EPR_C_IRPTE = 5;
    localparam int EPR_C_UCLE = 6;
    localparam int EPR_C_DEVA = 7;
    localparam int EPR_C_DEVB = 8;
    localparam int EPR_C_BRTE = 9;
    localparam int EPR_C_TRAPE = 10;
    localparam int EPR_C_RETE = 11;
    localparam logic [EPR_CW-1:0] EPR_CTRL_RST = 12'h000;
    // Status fields
    localparam int EPR_S_VALID = 0;
    localparam int EPR_S_PRIO = 8;
    localparam int EPR_S_IDX = 16;
    // Sticky asynchronous pending bits
    localparam int EPR_PB_DBG = 0;
    localparam int EPR_PB_WDOG = 1;
    localparam int EPR_PB_FIT = 2;
    localparam int EPR_PB_DEC = 3;
    localparam int EPR_PB_PM = 4;
    // Pin synchroniser: bits 0..4 are active low, idle high
    localparam logic [7:0] EPR_PIN_RST = 8'h1F;
    // ************************************************************
    // Vector offset index per priority level
    // ************************************************************
    localparam logic [5:0] EPR_IX_TRAP = 6'h06;
    localparam logic [5:0] EPR_IX_SC = 6'h08;
    localparam logic [5:0] EPR_IX_FPD = 6'h21;
    localparam logic [5:0] EPR_IX_FPR = 6'h22;
    localparam logic [5:0] EPR_IX_TAB [EPR_NPRI] = '{
        6'h00, 6'h01, 6'h00, 6'h0F, 6'h00, 6'h0C, 6'h04, 6'h0B, 6'h0A,
        6'h23, 6'h0F, 6'h0E, 6'h00, 6'h06, 6'h06, 6'h20, 6'h06, 6'h0F,
        6'h06, 6'h05, 6'h0F, 6'h0D, 6'h02, 6'h00, 6'h0F, 6'h0F, 6'h0F};
endpackage

// ===== hw/epr_sel_if.sv
// Request and winner bundle between the resolver and its picker
`timescale 1ns/10ps
`default_nettype none
interface epr_sel_if;
    import epr_pkg::*;
    logic clk;
    logic [EPR_NPRI-1:0] req;
    logic [5:0] idx [EPR_NPRI];
    logic hit;
    logic [4:0] prio;
    logic [5:0] vec;
    modport drv (output clk, req, idx, input hit, prio, vec);
    modport pick (input clk, req, idx, output hit, prio, vec);
endinterface
`default_nettype wire

// ===== hw/epr_top.sv
// Exception recognition and priority resolution with APB control
//
// Functional notes
// RULE1: reset sources win at once, always
// RULE2: NMI outranks everything except reset
// RULE3: machine check level 1, index 1
// RULE4: async maskable events stay pending, need recoverable
// RULE5: async debug events level 3, index 15
// RULE6: critical 4, watchdog 5, external 6
// RULE7: timer level 7 index 11, decrementer 8
// RULE8: performance monitor level 9, index 35
// RULE9: reset and machine check never delayed
// RULE10: interrupt-taken debug is synchronous, already recoverable
// RULE11: fetch tag taken when next, dropped on redirect
// RULE12: address compare 10, translation miss 11
// RULE13: instruction storage faults at level 12
// RULE14: execute faults wait older completion, older wins
// RULE15: post-completion debug dropped by higher fault
// RULE16: illegal 13, privileged user 14, index 6
// RULE17: unit unavailable level 15, index 32
// RULE18: branch, trap, return debug level 17
// RULE19: level 18 trap, call, float data, round
// RULE20: alignment faults level 19, index 5
// RULE21: compare with data fault is imprecise debug
// RULE22: data miss 21, data storage 22
// RULE23: external enable gates, cleared on taking
// RULE24: one highest winner presented each cycle
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module epr_top
    import epr_pkg::*;
#(
    parameter logic [5:0] ISI_INDEX = 6'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sys_reset_pin_n,
    input wire logic nmi_pin_n,
    input wire logic mcheck_pin_n,
    input wire logic critical_pin_n,
    input wire logic ext_irq_pin_n,
    input wire logic uncond_debug_pin,
    input wire logic ext_debug_event_pin_a,
    input wire logic ext_debug_event_pin_b,
    input wire logic wdog_reset_ctl,
    input wire logic dbg_reset_ctl,
    input wire logic cache_parity_err,
    input wire logic handler_fetch_fault,
    input wire logic ext_bus_err,
    input wire logic debug_counter_a_event,
    input wire logic debug_counter_b_event,
    input wire logic imprecise_debug_event,
    input wire logic wdog_timeout,
    input wire logic fixed_interval_timer,
    input wire logic decrementer_evt,
    input wire logic perf_mon_evt,
    input wire logic recoverable,
    input wire logic user_mode,
    input wire logic fetch_exc_valid,
    input wire logic fetch_iac,
    input wire logic fetch_itlb_miss,
    input wire logic fetch_isi,
    input wire logic fetch_next_exec,
    input wire logic redirect,
    input wire logic exec_valid,
    input wire logic exec_illegal,
    input wire logic exec_priv,
    input wire logic exec_unavail,
    input wire logic exec_brt,
    input wire logic exec_trap,
    input wire logic exec_ret,
    input wire logic exec_cret,
    input wire logic exec_sc,
    input wire logic exec_fp_data,
    input wire logic exec_fp_round,
    input wire logic exec_align,
    input wire logic exec_dac,
    input wire logic data_translation_miss,
    input wire logic exec_dsi,
    input wire logic exec_cache_lock,
    input wire logic older_done,
    input wire logic older_exc,
    input wire logic instr_complete,
    input wire logic post_dac,
    input wire logic post_icmp,
    input wire logic take_ack,
    output logic exc_valid,
    output logic [4:0] exc_priority,
    output logic [5:0] vector_offset_index,
    output logic imprecise_debug_flag
);
    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    logic [7:0] pin_m_reg;
    logic [7:0] pin_s_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_m_reg <= EPR_PIN_RST;
            pin_s_reg <= EPR_PIN_RST;
        end else begin
            pin_m_reg <= {ext_debug_event_pin_b, ext_debug_event_pin_a,
                uncond_debug_pin, ext_irq_pin_n, critical_pin_n,
                mcheck_pin_n, nmi_pin_n, sys_reset_pin_n};
            pin_s_reg <= pin_m_reg;
        end
    end
    wire logic rst_pin = ~pin_s_reg[0];
    wire logic nmi_pin = ~pin_s_reg[1];
    wire logic mcp_pin = ~pin_s_reg[2];
    wire logic crit_pin = ~pin_s_reg[3];
    wire logic ext_pin = ~pin_s_reg[4];
    // ************************************************************
    // State registers
    // ************************************************************
    logic [EPR_CW-1:0] ctrl_reg;
    logic [EPR_CW-1:0] ctrl_next;
    logic [EPR_PW-1:0] pend_reg;
    logic [EPR_PW-1:0] pend_next;
    logic [2:0] fetch_reg;
    logic [2:0] fetch_next;
    logic [EPR_XW-1:0] exec_reg;
    logic [EPR_XW-1:0] exec_next;
    logic irpt_reg;
    logic irpt_next;
    logic dbg_flag_reg;
    logic dbg_flag_next;
    logic exc_valid_reg;
    logic [4:0] exc_prio_reg;
    logic [5:0] exc_vec_reg;
    logic [31:0] prdata_reg;
    // Control bits by name
    wire logic ee = ctrl_reg[EPR_C_EE];
    wire logic ce = ctrl_reg[EPR_C_CE];
    wire logic de = ctrl_reg[EPR_C_DE];
    wire logic idm = ctrl_reg[EPR_C_IDM];
    wire logic dbg_on = de & idm;
    // ************************************************************
    // APB decode
    // ************************************************************
    wire logic setup = psel & ~penable;
    wire logic access = psel & penable;
    wire logic a_ctrl = (paddr == EPR_CTRL_OFF);
    wire logic a_stat = (paddr == EPR_STAT_OFF);
    wire logic a_pend = (paddr == EPR_PEND_OFF);
    wire logic a_dbg = (paddr == EPR_DBG_OFF);
    wire logic a_hit = a_ctrl | a_stat | a_pend | a_dbg;
    wire logic wr = access & pwrite & a_hit;
    wire logic wr_ctrl = wr & a_ctrl;
    wire logic [EPR_PW-1:0] cancel = (wr & a_pend) ? pwdata[EPR_PW-1:0] : '0;
    wire logic dbg_clr = wr & a_dbg & pwdata[0];
    assign pready = 1'b1;
    assign pslverr = access & ~a_hit;
    assign prdata = prdata_reg;
    // Read mux, sampled in the setup cycle
    wire logic [31:0] stat_word = {10'h000, exc_vec_reg, 3'h0, exc_prio_reg,
        7'h00, exc_valid_reg};
    wire logic [31:0] rd_word = a_ctrl ? {20'h00000, ctrl_reg} :
        a_stat ? stat_word :
        a_pend ? {27'h0000000, pend_reg} :
        a_dbg ? {31'h00000000, dbg_flag_reg} : 32'h00000000;
    // ************************************************************
    // Taking the presented winner
    // ************************************************************
    wire logic take = take_ack & exc_valid_reg;
    wire logic [4:0] tp = exc_prio_reg;
    wire logic t_dbg = (tp == 5'h03) | (tp == 5'h0A) | (tp == 5'h11) |
        (tp == 5'h14) | (tp >= 5'h18);
    wire logic t_fetch = take & (tp >= 5'h0A) & (tp <= 5'h0C);
    wire logic t_exec = take & (tp >= 5'h0D) & (tp <= 5'h16);
    wire logic t_int = take & ~t_dbg & (tp >= 5'h04) & (tp <= 5'h16);
    wire logic t_crit = take & ((tp == 5'h01) | (tp == 5'h04) | (tp == 5'h05));
    wire logic ee_clr = take & ~t_dbg & (tp != 5'h00);
    // RULE23: enable cleared when an interrupt is taken
    always_comb begin
        ctrl_next = wr_ctrl ? pwdata[EPR_CW-1:0] : ctrl_reg;
        if (ee_clr) begin
            ctrl_next[EPR_C_EE] = 1'b0;
        end
        if (t_crit) begin
            ctrl_next[EPR_C_CE] = 1'b0;
        end
        if (take & t_dbg) begin
            ctrl_next[EPR_C_DE] = 1'b0;
        end
    end
    // ************************************************************
    // Asynchronous sticky pending
    // ************************************************************
    wire logic dbg_evt = pin_s_reg[5] | (pin_s_reg[6] & ctrl_reg[EPR_C_DEVA]) |
        (pin_s_reg[7] & ctrl_reg[EPR_C_DEVB]) | debug_counter_a_event |
        debug_counter_b_event | imprecise_debug_event;
    wire logic [EPR_PW-1:0] pend_set = {perf_mon_evt, decrementer_evt,
        fixed_interval_timer, wdog_timeout, dbg_evt};
    wire logic [EPR_PW-1:0] pend_take = {take & (tp == 5'h09),
        take & (tp == 5'h08), take & (tp == 5'h07), take & (tp == 5'h05),
        take & (tp == 5'h03)};
    // RULE4: held until taken or cancelled, set wins
    assign pend_next = pend_set | (pend_reg & ~pend_take & ~cancel);
    // RULE10: interrupt-taken debug queued at context switch
    assign irpt_next = (t_int & ctrl_reg[EPR_C_IRPTE] & dbg_on) |
        (irpt_reg & ~(take & (tp == 5'h18)));
    // ************************************************************
    // Fetch tag and execute pending
    // ************************************************************
    // RULE11: redirect discards the tag
    assign fetch_next = redirect ? 3'h0 :
        fetch_exc_valid ? {fetch_isi, fetch_itlb_miss, fetch_iac & idm} :
        t_fetch ? 3'h0 : fetch_reg;
    wire logic trap_dbg = exec_trap & ctrl_reg[EPR_C_TRAPE] & dbg_on;
    // RULE18: debug on branch, trap, return events
    wire logic dbg17 = dbg_on & ((exec_brt & ctrl_reg[EPR_C_BRTE]) |
        trap_dbg | ((exec_ret | exec_cret) & ctrl_reg[EPR_C_RETE]));
    // RULE22: user cache locking without user lock enable
    wire logic dsi_all = exec_dsi |
        (exec_cache_lock & user_mode & ~ctrl_reg[EPR_C_UCLE]);
    wire logic [EPR_XW-1:0] exec_cap = {dsi_all, data_translation_miss,
        exec_dac & dbg_on, exec_align, exec_fp_round, exec_fp_data, exec_sc,
        exec_trap & ~trap_dbg, dbg17, exec_unavail, exec_priv & user_mode,
        exec_illegal};
    // RULE14: older exception discards the pending one
    assign exec_next = older_exc ? '0 :
        exec_valid ? exec_cap :
        t_exec ? '0 : exec_reg;
    // RULE21: imprecise flag set on taking, set wins
    assign dbg_flag_next = (take & (tp == 5'h14)) | (dbg_flag_reg & ~dbg_clr);
    // ************************************************************
    // Request vector
    // ************************************************************
    epr_sel_if sel ();
    assign sel.clk = pclk;
    wire logic rec = recoverable;
    wire logic mchk = nmi_pin | (mcp_pin & ctrl_reg[EPR_C_MCPE]) |
        cache_parity_err | handler_fetch_fault | ext_bus_err;
    wire logic fe = fetch_next_exec & rec;
    wire logic xe = older_done;
    wire logic [EPR_XW-1:0] x = exec_reg;
    wire logic post_ok = instr_complete & dbg_on;
    always_comb begin
        sel.req = '0;
        // RULE1: reset ignores recoverability
        sel.req[0] = rst_pin | wdog_reset_ctl | dbg_reset_ctl;
        // RULE2 RULE3 RULE9: machine check, never held
        sel.req[1] = mchk;
        // RULE5: async debug events
        sel.req[3] = (pend_reg[EPR_PB_DBG] | dbg_evt) & de & rec;
        // RULE6: critical and watchdog need critical enable
        sel.req[4] = crit_pin & ce & rec;
        sel.req[5] = pend_reg[EPR_PB_WDOG] & ce & rec;
        // RULE23: non-critical sources wait for external enable
        sel.req[6] = ext_pin & ee & rec;
        // RULE7: timer and decrementer
        sel.req[7] = pend_reg[EPR_PB_FIT] & ee & rec;
        sel.req[8] = pend_reg[EPR_PB_DEC] & ee & rec;
        // RULE8: lowest async source
        sel.req[9] = pend_reg[EPR_PB_PM] & ee & rec;
        // RULE12: compare and translation miss at fetch
        sel.req[10] = fetch_reg[0] & fe;
        sel.req[11] = fetch_reg[1] & fe;
        // RULE13: instruction storage at fetch
        sel.req[12] = fetch_reg[2] & fe;
        // RULE16: illegal and privileged
        sel.req[13] = x[0] & xe;
        sel.req[14] = x[1] & xe;
        // RULE17: unit unavailable
        sel.req[15] = x[2] & xe;
        sel.req[17] = x[3] & xe;
        // RULE19: trap, call, float data and round
        sel.req[18] = (x[4] | x[5] | x[6] | x[7]) & xe;
        // RULE20: alignment
        sel.req[19] = x[8] & xe;
        // RULE21: compare coinciding with data fault
        sel.req[20] = x[9] & (x[10] | x[11] | mchk) & xe;
        // RULE22: data miss and data storage
        sel.req[21] = x[10] & xe;
        sel.req[22] = x[11] & xe;
        sel.req[24] = irpt_reg;
        // RULE15: post-completion debug, lower than all faults
        sel.req[25] = post_ok & post_dac;
        sel.req[26] = post_ok & post_icmp;
    end
    // Index table with the level 12 and level 18 exceptions
    genvar g;
    generate
        for (g = 0; g < EPR_NPRI; g++) begin : g_idx
            if (g == 12) begin : g_isi
                assign sel.idx[g] = ISI_INDEX;
            end else if (g == 18) begin : g_l18
                assign sel.idx[g] = x[4] ? EPR_IX_TRAP : x[5] ? EPR_IX_SC :
                    x[6] ? EPR_IX_FPD : EPR_IX_FPR;
            end else begin : g_tab
                assign sel.idx[g] = EPR_IX_TAB[g];
            end
        end
    endgenerate
    epr_pick u_pick (
        .sel(sel)
    );
    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= EPR_CTRL_RST;
            pend_reg <= '0;
            fetch_reg <= 3'h0;
            exec_reg <= '0;
            irpt_reg <= 1'b0;
            dbg_flag_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            pend_reg <= pend_next;
            fetch_reg <= fetch_next;
            exec_reg <= exec_next;
            irpt_reg <= irpt_next;
            dbg_flag_reg <= dbg_flag_next;
        end
    end
    // RULE24: winner presented, withdrawn for a cycle on take
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_valid_reg <= 1'b0;
            exc_prio_reg <= 5'h00;
            exc_vec_reg <= 6'h00;
        end else begin
            exc_valid_reg <= sel.hit & ~take_ack;
            exc_prio_reg <= sel.prio;
            exc_vec_reg <= sel.vec;
        end
    end
    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (setup) begin
            prdata_reg <= rd_word;
        end
    end
    assign exc_valid = exc_valid_reg;
    assign exc_priority = exc_prio_reg;
    assign vector_offset_index = exc_vec_reg;
    assign imprecise_debug_flag = dbg_flag_reg;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic ee_rec = ee & rec;
    a_reset_first: assert property ((sel.req[0] && !take_ack)
        |=> (exc_valid_reg && exc_prio_reg == 5'h00))  // RULE1
        else $error("reset request not presented first");
    a_nmi_rank: assert property ((nmi_pin && !sel.req[0] && !take_ack)
        |=> (exc_prio_reg == 5'h01 && exc_vec_reg == 6'h01))  // RULE2
        else $error("nmi not presented as machine check");
    a_async_hold: assert property ((pend_reg[EPR_PB_FIT] && !take && !cancel[EPR_PB_FIT])
        |=> pend_reg[EPR_PB_FIT])  // RULE4
        else $error("timer pending lost");
    a_ee_gate: assert property ((exc_valid_reg && exc_prio_reg >= 5'h06 &&
        exc_prio_reg <= 5'h09) |-> $past(ee_rec))  // RULE23
        else $error("masked source presented");
    a_ee_clear: assert property ((take && exc_prio_reg == 5'h06)
        |=> !ctrl_reg[EPR_C_EE])  // RULE23
        else $error("external enable not cleared on take");
    a_fetch_drop: assert property (redirect |=> (fetch_reg == 3'h0))  // RULE11
        else $error("fetch tag kept across redirect");
    a_exec_wait: assert property ((exc_valid_reg && exc_prio_reg >= 5'h0D &&
        exc_prio_reg <= 5'h16) |-> $past(older_done))  // RULE14
        else $error("execute fault taken before older completion");
    a_imp_flag: assert property ((take && exc_prio_reg == 5'h14)
        |=> dbg_flag_reg)  // RULE21
        else $error("imprecise flag not set");
    a_perf_index: assert property ((exc_valid_reg && exc_prio_reg == 5'h09)
        |-> exc_vec_reg == 6'h23)  // RULE8
        else $error("performance monitor index wrong");
endmodule
`default_nettype wire
